/* design/smc_params.svh */
// Purpose: constants for the sleep mode controller
// Assumes: 200 MHz system clock
// Notes: mode codes, counter width and wake timing
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_ADCQ 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_HOLD_CYCLES 8'h04
`define SMC_STBY_CYCLES 8'h06
`define SMC_CNT_W 20
`endif

/* design/smc_pkg.sv */
// Purpose: types of the sleep mode controller
// Assumes: nothing
// Notes: clock enables travel as one struct
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_RUN = 2'b00,
    SMC_SLEEP = 2'b01,
    SMC_START = 2'b10,
    SMC_HOLD = 2'b11
  } smc_state_e;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic async_clk;
    logic main_osc;
    logic timer_osc;
  } smc_clk_en_s;
endpackage

/* design/smc_sleep_ctrl.sv */
// Purpose: sleep mode controller: gates clock domains, picks wake sources, holds core
// Assumes: sleep_exec_i is a one-cycle pulse from the core on the same clock
// Notes: reset of any kind clears state; memories keep contents as no clock gate
//   touches their data, only their clocks
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int CNT_W = `SMC_CNT_W,
  parameter logic [CNT_W-1:0] HOLD_CYCLES = CNT_W'(`SMC_HOLD_CYCLES),
  parameter logic [CNT_W-1:0] STBY_CYCLES = CNT_W'(`SMC_STBY_CYCLES)
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sleep_exec_i,
  input wire logic sleep_arm_i,
  input wire logic [2:0] sleep_mode_select_i,
  input wire logic [CNT_W-1:0] startup_cycles_i,
  input wire logic ext_crystal_i,
  input wire logic adc_enable_i,
  input wire logic timer2_running_i,
  input wire logic timer2_async_i,
  input wire logic [7:0] ext_irq_lines_i,
  input wire logic [7:0] ext_irq_level_mode_i,
  input wire logic pin_change_i,
  input wire logic twi_match_i,
  input wire logic twi_irq_i,
  input wire logic timer2_irq_i,
  input wire logic spm_ee_ready_irq_i,
  input wire logic adc_done_irq_i,
  input wire logic wdt_irq_i,
  input wire logic other_io_irq_i,
  output smc_clk_en_s clk_en_o,
  output logic cpu_halt_o,
  output logic sleeping_o,
  output logic adc_start_o,
  output logic irq_take_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin sync
  logic [7:0] ext_s;
  smc_sync2 #(.W(8)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(ext_irq_lines_i),
    .q_o(ext_s)
  );

  // elaboration check: the counter must hold the hold and standby counts
  if (CNT_W < 4) begin : g_cnt_w_chk
    $error("CNT_W too small for the wake hold counts");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  smc_state_e state_q;
  logic [2:0] mode_q;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic cnt_done;
  logic wake;
  logic enter;

  // deep modes stop the main oscillator (except power-save with timer2 running synchronously) and need the fuse restart time
  function automatic logic is_deep(input logic [2:0] m);
    is_deep = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE);
  endfunction

  // standby codes are honoured only with an external crystal; else standby becomes power-down and extended standby power-save
  function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xtal);
    if ((m == `SMC_MODE_STBY || m == `SMC_MODE_XSTBY) && !xtal) begin
      eff_mode = (m == `SMC_MODE_STBY) ? `SMC_MODE_PDOWN : `SMC_MODE_PSAVE;
    end else begin
      eff_mode = m;
    end
  endfunction

  // reserved codes 100/101 do not sleep at all
  assign enter = sleep_exec_i && sleep_arm_i && (state_q == SMC_RUN) &&
    !(sleep_mode_select_i == 3'h4 || sleep_mode_select_i == 3'h5);

  ////////////////////////////////////////////////////////////////////////////
  // wake source decode per mode
  logic upper_lvl;
  logic lower_any;
  logic async_t2;
  always_comb begin
    upper_lvl = |(ext_s[7:4] & ext_irq_level_mode_i[7:4]);
    lower_any = |ext_s[3:0];
    async_t2 = timer2_running_i && timer2_async_i;
    wake = 1'b0;
    unique case (mode_q)
      `SMC_MODE_IDLE: begin
        wake = |ext_s || pin_change_i || twi_match_i || twi_irq_i || timer2_irq_i ||
          spm_ee_ready_irq_i || adc_done_irq_i || wdt_irq_i || other_io_irq_i;
      end
      `SMC_MODE_ADCQ: begin
        wake = adc_done_irq_i || wdt_irq_i || twi_irq_i || twi_match_i ||
          (timer2_irq_i && async_t2) || spm_ee_ready_irq_i || upper_lvl ||
          lower_any || pin_change_i;
      end
      `SMC_MODE_PDOWN, `SMC_MODE_STBY: begin
        wake = twi_match_i || upper_lvl || lower_any || pin_change_i || wdt_irq_i;
      end
      `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: begin
        wake = twi_match_i || upper_lvl || lower_any || pin_change_i || wdt_irq_i ||
          (timer2_irq_i && timer2_running_i);
      end
      default: wake = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake delay selection: fuse start-up in deep modes, six cycles in standby
  always_comb begin
    cnt_load = 1'b0;
    cnt_val = HOLD_CYCLES;
    if (state_q == SMC_SLEEP && wake) begin
      cnt_load = 1'b1;
      if (is_deep(mode_q)) begin
        cnt_val = startup_cycles_i;
      end else if (mode_q == `SMC_MODE_STBY || mode_q == `SMC_MODE_XSTBY) begin
        cnt_val = STBY_CYCLES;
      end else begin
        cnt_val = '0;
      end
    end else if (state_q == SMC_START && cnt_done) begin
      cnt_load = 1'b1;
      cnt_val = HOLD_CYCLES - CNT_W'(1);
    end
  end

  smc_wake_cnt #(.W(CNT_W)) u_cnt (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(cnt_load),
    .val_i(cnt_val),
    .done_o(cnt_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; a reset drops straight back to run from the reset vector
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SMC_RUN;
    end else begin
      unique case (state_q)
        SMC_RUN: if (enter) state_q <= SMC_SLEEP;
        SMC_SLEEP: if (wake) state_q <= SMC_START;
        SMC_START: if (cnt_done) state_q <= SMC_HOLD;
        SMC_HOLD: if (cnt_done) state_q <= SMC_RUN;
      endcase
    end
  end

  // mode captured at entry so later writes do not disturb the sleep
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= `SMC_MODE_IDLE;
    end else if (enter) begin
      mode_q <= eff_mode(sleep_mode_select_i, ext_crystal_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enables; only clocks are gated, memory contents stay intact
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_en_o <= '{default: 1'b1};
    end else if (state_q == SMC_SLEEP && !wake) begin
      clk_en_o.cpu <= 1'b0;
      clk_en_o.flash <= 1'b0;
      clk_en_o.io <= (mode_q == `SMC_MODE_IDLE);
      clk_en_o.adc <= (mode_q == `SMC_MODE_IDLE) || (mode_q == `SMC_MODE_ADCQ);
      clk_en_o.async_clk <= async_t2 && (mode_q != `SMC_MODE_PDOWN) &&
        (mode_q != `SMC_MODE_STBY);
      clk_en_o.timer_osc <= async_t2 && (mode_q != `SMC_MODE_PDOWN) &&
        (mode_q != `SMC_MODE_STBY);
      clk_en_o.main_osc <= (mode_q == `SMC_MODE_IDLE) || (mode_q == `SMC_MODE_ADCQ) ||
        (mode_q == `SMC_MODE_STBY) || (mode_q == `SMC_MODE_XSTBY) ||
        ((mode_q == `SMC_MODE_PSAVE) && timer2_running_i && !timer2_async_i);
    end else if (state_q == SMC_START || state_q == SMC_HOLD) begin
      // peripherals and oscillators resume first; core stays off through the hold
      clk_en_o <= '{default: 1'b1};
      clk_en_o.cpu <= (state_q == SMC_HOLD) && cnt_done;
      clk_en_o.flash <= (state_q == SMC_HOLD) && cnt_done;
    end else if (state_q == SMC_RUN && !enter) begin
      clk_en_o <= '{default: 1'b1};
    end else if (enter) begin
      clk_en_o.cpu <= 1'b0;
      clk_en_o.flash <= 1'b0;
    end
  end

  // status outputs and pulses
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_halt_o <= 1'b0;
      sleeping_o <= 1'b0;
      adc_start_o <= 1'b0;
      irq_take_o <= 1'b0;
    end else begin
      cpu_halt_o <= enter || (state_q != SMC_RUN && !(state_q == SMC_HOLD && cnt_done));
      sleeping_o <= enter || (state_q == SMC_SLEEP && !wake);
      adc_start_o <= enter && adc_enable_i &&
        (sleep_mode_select_i == `SMC_MODE_IDLE || sleep_mode_select_i == `SMC_MODE_ADCQ);
      irq_take_o <= (state_q == SMC_HOLD) && cnt_done;
    end
  end
endmodule // smc_sleep_ctrl

/* design/smc_sync2.sv */
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module smc_sync2 #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  // two stages, reset to zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= '0;
      q_o <= '0;
    end else begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule // smc_sync2

/* design/smc_wake_cnt.sv */
// Purpose: wake delay counter
// Assumes: load takes priority over counting
// Notes: done pulses one cycle when the count reaches zero
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_wake_cnt #(
  parameter int W = `SMC_CNT_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [W-1:0] val_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic run_q;
  // down counter; a zero load ends after one cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_q <= val_i;
      run_q <= 1'b1;
      done_o <= 1'b0;
    end else if (run_q) begin
      done_o <= (cnt_q <= W'(1));
      run_q <= (cnt_q > W'(1));
      cnt_q <= (cnt_q == '0) ? '0 : cnt_q - W'(1);
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule // smc_wake_cnt

/* sim/smc_core_model.sv */
// Purpose: core issuing sleep and external lines waking it
// Assumes: bench calls the tasks after a rising edge
// Notes: lines drop only once the core is released
`timescale 1ns/1ps
module smc_core_model (
  input wire logic clk_i,
  input wire logic cpu_halt_i,
  output logic sleep_exec_o,
  output logic sleep_arm_o,
  output logic [7:0] ext_lines_o
);
  initial begin
    sleep_exec_o = 1'b0;
    sleep_arm_o = 1'b0;
    ext_lines_o = 8'h00;
  end
  // arm and sleep instruction set together; sleep drops after one cycle, arm stays set
  task automatic sleep_instr(input logic arm);
    @(posedge clk_i);
    #1 sleep_arm_o = arm;
    sleep_exec_o = 1'b1;
    @(posedge clk_i);
    #1 sleep_exec_o = 1'b0;
  endtask
  // a level wake is held until release so it cannot be missed
  always @(posedge clk_i) begin
    if (!cpu_halt_i) ext_lines_o <= 8'h00;
  end
endmodule // smc_core_model

/* sim/smc_sleep_ctrl_bench.sv */
// Purpose: self-checking bench of the sleep controller
// Assumes: restart delay kept small
// Notes: wake latency checked with no slack below and four cycles of slack above
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_sleep_ctrl_bench;
  import smc_pkg::*;
  logic clk_i = 0;
  logic resetn_i = 0;
  logic [2:0] mode = 0;
  logic [19:0] startup = 20'h0_000c;
  logic xtal = 0, adc_en = 0, t2_async = 0;
  logic [7:0] lvl = 0, irqs = 0, lfsr = 8'h38;
  logic exec, arm, halt, sleeping, adc_start, take;
  logic [7:0] ext;
  smc_clk_en_s clk_en;
  int exp_q[$];
  int cyc = 0, wake_t = 0, takes = 0, fails = 0, cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  smc_core_model u_core (.clk_i(clk_i), .cpu_halt_i(halt), .sleep_exec_o(exec),
    .sleep_arm_o(arm), .ext_lines_o(ext));
  smc_sleep_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sleep_exec_i(exec),
    .sleep_arm_i(arm), .sleep_mode_select_i(mode), .startup_cycles_i(startup),
    .ext_crystal_i(xtal), .adc_enable_i(adc_en), .timer2_running_i(1'b1),
    .timer2_async_i(t2_async), .ext_irq_lines_i(ext), .ext_irq_level_mode_i(lvl),
    .pin_change_i(irqs[7]), .twi_match_i(irqs[6]), .twi_irq_i(irqs[5]), .timer2_irq_i(irqs[4]),
    .spm_ee_ready_irq_i(irqs[3]), .adc_done_irq_i(irqs[2]), .wdt_irq_i(irqs[1]),
    .other_io_irq_i(irqs[0]), .clk_en_o(clk_en), .cpu_halt_o(halt), .sleeping_o(sleeping),
    .adc_start_o(adc_start), .irq_take_o(take));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // enter, offer sources that must be ignored, then wake; d < 0 means fuse delay
  task automatic run_case(input logic [2:0] md, input logic xt, input logic [7:0] ign,
      input logic [7:0] ign_x, input logic [7:0] wk, input logic [7:0] wk_x, input int d);
    int n;
    lfsr = lfsr_next(lfsr);
    mode = md;
    xtal = xt;
    t2_async = lfsr[0];
    adc_en = lfsr[1];
    startup = 20'(12 + lfsr[4:2]);
    u_core.sleep_instr(1'b1);
    chk(sleeping === 1'b1 && halt === 1'b1, "sleep not entered");
    chk(adc_start === (adc_en && md[2:1] == 2'b00), "adc start on entry wrong");
    #1 irqs = ign;
    u_core.ext_lines_o = ign_x;
    repeat (20) @(posedge clk_i);
    #1 chk(sleeping === 1'b1, "woke on a source not allowed");
    n = takes;
    exp_q.push_back((d < 0 ? int'(startup) : d) + 4 + (wk_x != 0 ? 2 : 0));
    wake_t = cyc;
    irqs = wk;
    u_core.ext_lines_o = ign_x | wk_x;
    repeat (100) if (takes == n) @(posedge clk_i);
    #1 irqs = 8'h00;
    chk(takes == n + 1 && sleeping === 1'b0, "no wake");
  endtask
  ////////////////////////////////////////////////////////////////
  // monitor: each release is matched to the oldest note
  always @(posedge clk_i) begin : mon
    int e;
    cyc <= cyc + 1;
    if (resetn_i && take === 1'b1) begin
      takes++;
      if (exp_q.size() == 0) chk(1'b0, "release without wake");
      else begin
        e = exp_q.pop_front();
        chk(cyc - wake_t >= e && cyc - wake_t <= e + 4, "wake latency off");
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1;
    run_case(`SMC_MODE_IDLE, 0, 0, 0, 8'h01, 0, 0);
    run_case(`SMC_MODE_ADCQ, 0, 8'h01, 0, 8'h04, 0, 0);
    run_case(`SMC_MODE_PDOWN, 0, 8'h15, 8'h10, 0, 8'h01, -1);
    run_case(`SMC_MODE_PSAVE, 0, 8'h04, 0, 8'h10, 0, -1);
    run_case(`SMC_MODE_STBY, 1, 8'h10, 0, 8'h40, 0, 6);
    run_case(`SMC_MODE_XSTBY, 1, 8'h04, 0, 8'h10, 0, 6);
    run_case(`SMC_MODE_STBY, 0, 8'h10, 0, 8'h80, 0, -1);
    lvl = 8'hf0;
    run_case(`SMC_MODE_ADCQ, 0, 0, 0, 0, 8'h20, 0);
    u_core.sleep_instr(1'b0);
    chk(sleeping === 1'b0 && halt === 1'b0 && clk_en === 7'h7f, "unarmed sleep acted");
    mode = 3'h4;
    u_core.sleep_instr(1'b1);
    chk(sleeping === 1'b0 && halt === 1'b0, "reserved code slept");
    mode = `SMC_MODE_PDOWN;
    u_core.sleep_instr(1'b1);
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 0;
    #1 chk(sleeping === 1'b0 && halt === 1'b0 && clk_en === 7'h7f, "reset left sleep");
    @(posedge clk_i);
    #1 resetn_i = 1;
    repeat (20) @(posedge clk_i);
    report_and_stop();
  end
endmodule // smc_sleep_ctrl_bench

/* sim/smc_sleep_ctrl_sva.sv */
// Purpose: port checker for the sleep controller
// Assumes: mode and timer2 mode held steady while asleep
// Notes: wake timing has slack, counts are approximate
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_sleep_ctrl_sva
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sleep_exec_i,
  input wire logic sleep_arm_i,
  input wire logic [2:0] sleep_mode_select_i,
  input wire logic adc_enable_i,
  input wire logic timer2_async_i,
  input wire smc_clk_en_s clk_en_o,
  input wire logic cpu_halt_o,
  input wire logic sleeping_o,
  input wire logic adc_start_o,
  input wire logic irq_take_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////
  // sleep request accepted in run with a legal code
  sequence s_take;
    sleep_exec_i && !cpu_halt_o && sleep_mode_select_i[2:1] != 2'b10;
  endsequence
  // settled sleep, gates of the second cycle in force
  sequence s_deep;
    sleeping_o && $past(sleeping_o);
  endsequence
  property p_enter;
    s_take ##0 sleep_arm_i |=> sleeping_o && cpu_halt_o;
  endproperty
  a_enter: assert property (p_enter) else $error("armed sleep not entered");
  property p_noop;
    s_take ##0 !sleep_arm_i |=> !sleeping_o && !cpu_halt_o;
  endproperty
  a_noop: assert property (p_noop) else $error("unarmed sleep not ignored");
  property p_gate;
    sleeping_o |-> !clk_en_o.cpu && !clk_en_o.flash;
  endproperty
  a_gate: assert property (p_gate) else $error("cpu clock runs in sleep");
  property p_idle;
    s_deep ##0 sleep_mode_select_i == `SMC_MODE_IDLE |-> clk_en_o.io && clk_en_o.adc;
  endproperty
  a_idle: assert property (p_idle) else $error("idle stopped io clock");
  property p_adcq;
    s_deep ##0 sleep_mode_select_i == `SMC_MODE_ADCQ |-> !clk_en_o.io && clk_en_o.adc;
  endproperty
  a_adcq: assert property (p_adcq) else $error("adc quiet gates wrong");
  property p_pdown;
    s_deep ##0 sleep_mode_select_i == `SMC_MODE_PDOWN |-> !clk_en_o.adc && !clk_en_o.main_osc;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down clock runs");
  property p_async;
    s_deep ##0 !timer2_async_i |-> !clk_en_o.async_clk && !clk_en_o.timer_osc;
  endproperty
  a_async: assert property (p_async) else $error("timer osc runs while sync");
  property p_adc;
    s_take ##0 sleep_arm_i && adc_enable_i && sleep_mode_select_i[2:1] == 2'b00 |=> adc_start_o;
  endproperty
  a_adc: assert property (p_adc) else $error("no adc start on entry");
  // the hold must outlast three cycles, and release must follow within 62 cycles of the wake
  property p_wake;
    $fell(sleeping_o) |-> cpu_halt_o [*3] ##[1:60] (irq_take_o && clk_en_o.cpu && !cpu_halt_o);
  endproperty
  a_wake: assert property (p_wake) else $error("wake release wrong");
endmodule // smc_sleep_ctrl_sva
bind smc_sleep_ctrl smc_sleep_ctrl_sva u_sva (.clk_i, .resetn_i, .sleep_exec_i, .sleep_arm_i,
  .sleep_mode_select_i, .adc_enable_i, .timer2_async_i, .clk_en_o, .cpu_halt_o, .sleeping_o,
  .adc_start_o, .irq_take_o);
